// >>> design/tsi_map.svh
// Register offsets and reset values of the touch sensor interrupt logic
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

`define TSI_STAGES 16
`define TSI_ADDR_W 10
`define TSI_DATA_W 16

`define TSI_OFS_LOW_EN 10'h005
`define TSI_OFS_HIGH_EN 10'h006
`define TSI_OFS_DONE_EN 10'h007
`define TSI_OFS_LOW_FLAGS 10'h008
`define TSI_OFS_HIGH_FLAGS 10'h009
`define TSI_OFS_DONE_FLAGS 10'h00A

`define TSI_RST_ENABLE 16'h0000
`define TSI_RST_FLAGS 16'h0000
`define TSI_RST_RDATA 16'h0000

`endif

// >>> design/tsi_pkg.sv
// Types shared by the touch sensor interrupt logic
`default_nettype none
`include "tsi_map.svh"

package tsi_pkg;
  typedef logic [`TSI_STAGES-1:0] tsi_stage_vec_t;
  typedef logic [`TSI_ADDR_W-1:0] tsi_addr_t;
  typedef logic [`TSI_DATA_W-1:0] tsi_data_t;
endpackage

`default_nettype wire

// >>> design/tsi_flag_if.sv
// Carrier between the register file and one group of status flags
`timescale 1ns/1ps
`default_nettype none

interface tsi_flag_if;
  tsi_pkg::tsi_stage_vec_t enable;
  tsi_pkg::tsi_stage_vec_t cond;
  logic rd_clear;
  tsi_pkg::tsi_stage_vec_t flags;
  logic pending;

  modport owner (
    input enable,
    input cond,
    input rd_clear,
    output flags,
    output pending
  );

  modport user (
    output enable,
    output cond,
    output rd_clear,
    input flags,
    input pending
  );
endinterface

`default_nettype wire

// >>> design/tsi_done_flags.sv
// Sticky conversion-complete flags with conditional clear on read
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"

module tsi_done_flags (
  input wire logic clk, // Conversion clock
  input wire logic rst, // Asynchronous reset, active high
  tsi_flag_if.owner grp // Enable, stage-done pulses, read clear, flags
);

  tsi_pkg::tsi_stage_vec_t flags;
  tsi_pkg::tsi_stage_vec_t set_bits;
  tsi_pkg::tsi_stage_vec_t clr_bits;
  tsi_pkg::tsi_stage_vec_t next_flags;

  // Only enabled stages latch; a read drops only bits whose cause is gone
  assign set_bits = grp.cond & grp.enable;
  assign clr_bits = grp.rd_clear ? ~grp.cond : '0;
  // Set wins over clear so a completion landing on the read is kept
  assign next_flags = (flags & ~clr_bits) | set_bits;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= `TSI_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // Disabling a stage later masks its stale flag off the alert line
  assign grp.flags = flags;
  assign grp.pending = |(flags & grp.enable);

endmodule

`default_nettype wire

// >>> design/tsi_limit_flags.sv
// Threshold activation state and change-triggered alert hold
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"

module tsi_limit_flags (
  input wire logic clk, // Conversion clock
  input wire logic rst, // Asynchronous reset, active high
  tsi_flag_if.owner low, // Low-limit group
  tsi_flag_if.owner high // High-limit group
);

  tsi_pkg::tsi_stage_vec_t low_state;
  tsi_pkg::tsi_stage_vec_t high_state;
  tsi_pkg::tsi_stage_vec_t low_seen;
  tsi_pkg::tsi_stage_vec_t high_seen;
  logic changed;
  logic held;
  logic low_read;
  logic high_read;
  logic both_read;
  logic next_held;
  logic next_low_read;
  logic next_high_read;

  // Only enabled stages can raise the alert on a change of state
  assign low_seen = low.cond & low.enable;
  assign high_seen = high.cond & high.enable;
  assign changed = (low_seen != (low_state & low.enable))
    | (high_seen != (high_state & high.enable));

  // Release needs reads of both registers since the last change of state
  assign next_low_read = held & (low_read | low.rd_clear);
  assign next_high_read = held & (high_read | high.rd_clear);
  assign both_read = next_low_read & next_high_read;
  // A fresh change in the same cycle as the last read keeps the line low
  assign next_held = changed | (held & ~both_read);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_state <= `TSI_RST_FLAGS;
      high_state <= `TSI_RST_FLAGS;
      held <= 1'b0;
      low_read <= 1'b0;
      high_read <= 1'b0;
    end else begin
      low_state <= low.cond;
      high_state <= high.cond;
      held <= next_held;
      low_read <= next_low_read & ~both_read & ~changed;
      high_read <= next_high_read & ~both_read & ~changed;
    end
  end

  // Status reads show present activation, not history
  assign low.flags = low_state;
  assign high.flags = high_state;
  assign low.pending = held;
  assign high.pending = held;

endmodule

`default_nettype wire

// >>> design/tsi_irq.sv
// Top of the touch sensor interrupt logic: registers, flag groups, alert pin
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"

module tsi_irq (
  input wire logic clk, // 40 MHz conversion clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [`TSI_STAGES-1:0] stage_done, // One-cycle pulse per finished stage
  input wire logic [`TSI_STAGES-1:0] low_active, // Stage below its low threshold
  input wire logic [`TSI_STAGES-1:0] high_active, // Stage above its high threshold
  input wire logic [`TSI_ADDR_W-1:0] reg_addr, // Register address from the serial port
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [`TSI_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read address set up, one cycle
  output logic [`TSI_DATA_W-1:0] reg_rdata, // Read data, registered
  output logic alert_n_out, // Open-drain alert level, always low
  output logic alert_n_oe // High while the alert line is pulled low
);

  tsi_pkg::tsi_stage_vec_t low_limit_irq_enable;
  tsi_pkg::tsi_stage_vec_t high_limit_irq_enable;
  tsi_pkg::tsi_stage_vec_t stage_done_irq_enable;
  tsi_pkg::tsi_data_t next_rdata;
  logic hit_low_en;
  logic hit_high_en;
  logic hit_done_en;
  logic hit_low_flags;
  logic hit_high_flags;
  logic hit_done_flags;
  logic alert;

  tsi_flag_if done_grp ();
  tsi_flag_if low_grp ();
  tsi_flag_if high_grp ();

  // Address decode shared by reads and writes
  assign hit_low_en = (reg_addr == `TSI_OFS_LOW_EN);
  assign hit_high_en = (reg_addr == `TSI_OFS_HIGH_EN);
  assign hit_done_en = (reg_addr == `TSI_OFS_DONE_EN);
  assign hit_low_flags = (reg_addr == `TSI_OFS_LOW_FLAGS);
  assign hit_high_flags = (reg_addr == `TSI_OFS_HIGH_FLAGS);
  assign hit_done_flags = (reg_addr == `TSI_OFS_DONE_FLAGS);

  // Enable registers; status registers ignore writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_limit_irq_enable <= `TSI_RST_ENABLE;
      high_limit_irq_enable <= `TSI_RST_ENABLE;
      stage_done_irq_enable <= `TSI_RST_ENABLE;
    end else if (reg_wr) begin
      if (hit_low_en) begin
        low_limit_irq_enable <= reg_wdata;
      end
      if (hit_high_en) begin
        high_limit_irq_enable <= reg_wdata;
      end
      if (hit_done_en) begin
        stage_done_irq_enable <= reg_wdata;
      end
    end
  end

  // Each source has its own enable and status group
  assign done_grp.enable = stage_done_irq_enable;
  assign done_grp.cond = stage_done;
  assign done_grp.rd_clear = reg_rd & hit_done_flags;
  assign low_grp.enable = low_limit_irq_enable;
  assign low_grp.cond = low_active;
  assign low_grp.rd_clear = reg_rd & hit_low_flags;
  assign high_grp.enable = high_limit_irq_enable;
  assign high_grp.cond = high_active;
  assign high_grp.rd_clear = reg_rd & hit_high_flags;

  tsi_done_flags u_done (
    .clk(clk),
    .rst(rst),
    .grp(done_grp)
  );

  tsi_limit_flags u_limit (
    .clk(clk),
    .rst(rst),
    .low(low_grp),
    .high(high_grp)
  );

  // Read mux captures status before the clear lands; unmapped reads give zero
  assign next_rdata = hit_low_en ? low_limit_irq_enable :
    hit_high_en ? high_limit_irq_enable :
    hit_done_en ? stage_done_irq_enable :
    hit_low_flags ? low_grp.flags :
    hit_high_flags ? high_grp.flags :
    hit_done_flags ? done_grp.flags :
    `TSI_RST_RDATA;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `TSI_RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Release follows the clear edge, well before the data bytes are shifted out
  assign alert = done_grp.pending | low_grp.pending;
  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert;

endmodule

`default_nettype wire

// >>> verification/tsi_irq_asserts.sv
// Port checks for the touch sensor interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"
module tsi_irq_asserts (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [`TSI_STAGES-1:0] stage_done, // Pulses
  input wire logic [`TSI_STAGES-1:0] low_active, // Low state
  input wire logic [`TSI_STAGES-1:0] high_active, // High state
  input wire logic [`TSI_ADDR_W-1:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic [`TSI_DATA_W-1:0] reg_wdata, // Data
  input wire logic reg_rd, // Read
  input wire logic [`TSI_DATA_W-1:0] reg_rdata, // Read data
  input wire logic alert_n_out, // Level
  input wire logic alert_n_oe // Drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] le, he, de;
  // Shadow enables, so the checks know which events must alert
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      le <= 16'h0000;
      he <= 16'h0000;
      de <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == 10'h005) le <= reg_wdata;
      if (reg_addr == 10'h006) he <= reg_wdata;
      if (reg_addr == 10'h007) de <= reg_wdata;
    end
  end
  chk_pin_low: assert property (alert_n_out == 1'b0)
    else $error("alert level not low");
  chk_done_alert: assert property (|(stage_done & de) |=> alert_n_oe)
    else $error("no alert after enabled stage");
  chk_done_sets: assert property (|(stage_done & de) ##1 !reg_rd ##1
    (reg_rd && reg_addr == 10'h00A) |=> |(reg_rdata & $past(stage_done, 3) & $past(de, 3)))
    else $error("done flag missing");
  chk_done_clear: assert property ((reg_rd && reg_addr == 10'h00A && ~|stage_done) ##1
    (!reg_rd && ~|stage_done) ##1 (reg_rd && reg_addr == 10'h00A && ~|stage_done)
    |=> reg_rdata == 16'h0000) else $error("done flags not cleared");
  chk_limit_alert: assert property (($changed(low_active & le) ||
    $changed(high_active & he)) && $stable(le) && $stable(he) |=> alert_n_oe)
    else $error("no alert on threshold change");
  chk_low_state: assert property (reg_rd && reg_addr == 10'h008 && $stable(low_active)
    && !$past(rst) |=> reg_rdata == $past(low_active)) else $error("low state wrong");
  chk_high_state: assert property (reg_rd && reg_addr == 10'h009 && $stable(high_active)
    && !$past(rst) |=> reg_rdata == $past(high_active)) else $error("high state wrong");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr < 10'h005 ||
    reg_addr > 10'h00A) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule
`default_nettype wire

// >>> verification/tsi_host.sv
// Host model: reads and writes the interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tsi_host (
  input wire logic clk, // Clock
  input wire tsi_pkg::tsi_data_t reg_rdata, // Read data
  output var tsi_pkg::tsi_addr_t reg_addr, // Address
  output var logic reg_wr, // Write strobe
  output var tsi_pkg::tsi_data_t reg_wdata, // Write data
  output var logic reg_rd // Read strobe
);
  initial begin
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // Data is scrambled after the write so stale values are never trusted
  task automatic wr(input tsi_pkg::tsi_addr_t a, input tsi_pkg::tsi_data_t d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // One strobe sets up the address; data is taken after that edge
  task automatic rd(input tsi_pkg::tsi_addr_t a, output tsi_pkg::tsi_data_t d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> verification/tsi_irq_bench.sv
// Self-checking bench for the touch sensor interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tsi_irq_bench;
  logic clk, rst, reg_wr, reg_rd, alert_n_out, alert_n_oe;
  tsi_pkg::tsi_stage_vec_t stage_done, low_active, high_active;
  tsi_pkg::tsi_addr_t reg_addr;
  tsi_pkg::tsi_data_t reg_wdata, reg_rdata, rv;
  int errors = 0;
  int cmp_count = 0;
  tsi_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  tsi_irq dut_u (.clk(clk), .rst(rst), .stage_done(stage_done), .low_active(low_active),
    .high_active(high_active), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
  task automatic chk(input string n, input tsi_pkg::tsi_data_t s, input tsi_pkg::tsi_data_t e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input tsi_pkg::tsi_addr_t a, input tsi_pkg::tsi_data_t e);
    host_u.rd(a, rv);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  task automatic al(input logic e);
    chk("alert", {15'h0000, alert_n_oe}, {15'h0000, e});
  endtask
  task automatic pulse(input tsi_pkg::tsi_stage_vec_t v);
    @(posedge clk);
    #1;
    stage_done = v;
    @(posedge clk);
    #1;
    stage_done = 16'h0000;
  endtask
  // Reset values, enable read-back, refused writes
  task automatic t_regs();
    for (int a = 5; a < 11; a++) rdc(10'(a), 16'h0000);
    for (int a = 5; a < 8; a++) begin
      host_u.wr(10'(a), 16'hA5C3 ^ 16'(a));
      rdc(10'(a), 16'hA5C3 ^ 16'(a));
    end
    host_u.wr(10'h3FF, 16'hFFFF);
    host_u.wr(10'h00A, 16'hFFFF);
    rdc(10'h3FF, 16'h0000);
    rdc(10'h00A, 16'h0000);
    host_u.wr(10'h005, 16'h0000);
    host_u.wr(10'h006, 16'h0000);
    al(1'b0);
  endtask
  // Stage-4 alert; a read racing a new pulse must not lose it
  task automatic t_done();
    host_u.wr(10'h007, 16'h0010);
    pulse(16'h0018);
    al(1'b1);
    fork
      rdc(10'h00A, 16'h0010);
      pulse(16'h0010);
    join
    al(1'b1);
    rdc(10'h00A, 16'h0010);
    al(1'b0);
    rdc(10'h00A, 16'h0000);
  endtask
  // The host reads both status words to release the line
  task automatic thr(input tsi_pkg::tsi_stage_vec_t lo, input tsi_pkg::tsi_stage_vec_t hi);
    @(posedge clk);
    #1;
    low_active = lo;
    high_active = hi;
    @(posedge clk);
    #1;
    al(1'b1);
    rdc(10'h008, lo);
    al(1'b1);
    rdc(10'h009, hi);
    al(1'b0);
  endtask
  // A disabled stage shows its state but never pulls the line
  task automatic t_masked();
    @(posedge clk);
    #1;
    low_active = 16'h0004;
    repeat (2) @(posedge clk);
    #1;
    al(1'b0);
    rdc(10'h008, 16'h0004);
    low_active = 16'h0000;
  endtask
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    stage_done = 16'h0000;
    low_active = 16'h0000;
    high_active = 16'h0000;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_done();
    host_u.wr(10'h005, 16'h0003);
    host_u.wr(10'h006, 16'h8000);
    thr(16'h0001, 16'h0000);
    thr(16'h0003, 16'h0000);
    thr(16'h0003, 16'h8000);
    thr(16'h0000, 16'h0000);
    t_masked();
    end_of_test();
  end
  // Watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
bind tsi_irq tsi_irq_asserts chk_u (.clk(clk), .rst(rst), .stage_done(stage_done),
  .low_active(low_active), .high_active(high_active), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_n_out(alert_n_out),
  .alert_n_oe(alert_n_oe));
`default_nettype wire
